// *** design/e1f_pkg.sv ***
// e1f_pkg: constants, register map and carriers of the e1 framer sync block
// assumes a 10 MHz system clock and a byte wide register port
package e1f_pkg;
   // register offsets
   localparam logic [7:0] OFS_FM_ONE      = 8'h00;
   localparam logic [7:0] OFS_FM_TWO      = 8'h01;
   localparam logic [7:0] OFS_FM_THREE    = 8'h02;
   localparam logic [7:0] OFS_LINE_CFG    = 8'h03;
   localparam logic [7:0] OFS_LOS_DETECT  = 8'h04;
   localparam logic [7:0] OFS_LOS_RECOVER = 8'h05;
   localparam logic [7:0] OFS_SPARE_CTL   = 8'h06;
   localparam logic [7:0] OFS_COMMAND     = 8'h07;
   localparam logic [7:0] OFS_STATUS      = 8'h08;
   localparam logic [7:0] OFS_INT_STAT    = 8'h09;
   localparam logic [7:0] OFS_INT_MASK    = 8'h0a;
   // field positions
   localparam int B_LINE_STD   = 3;
   localparam int B_RESYNC     = 1;
   localparam int B_RFS_HI     = 7;
   localparam int B_RFS_LO     = 6;
   localparam int B_AUTO_RAI   = 4;
   localparam int B_MF_RESYNC  = 0;
   localparam int B_EXT_IW     = 0;
   localparam int B_DIGITAL    = 3;
   localparam int B_AUTO_EBIT  = 3;
   localparam int B_EBIT_POL   = 2;
   localparam int B_RX_RESET   = 0;
   // interrupt bits
   localparam int I_LOS_SET    = 0;
   localparam int I_LOS_CLR    = 1;
   localparam int I_ALIGN_LOST = 2;
   localparam int I_MF_FOUND   = 3;
   localparam int I_IW400      = 4;
   localparam int I_RESYNC     = 5;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hff;
   // framing select encodings
   localparam logic [1:0] RFS_DOUBLE  = 2'h0;
   localparam logic [1:0] RFS_CRC4    = 2'h2;
   localparam logic [1:0] RFS_INTERWK = 2'h3;
   // line codes
   localparam logic [2:0] LC_NRZ      = 3'h0;
   localparam logic [2:0] LC_AMI      = 3'h1;
   localparam logic [2:0] LC_HDB3     = 3'h2;
   localparam logic [2:0] LC_CMI      = 3'h3;
   localparam logic [2:0] LC_CMI_HDB3 = 3'h4;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int SEC_MS        = 1000;
   localparam int MF_TIMEOUT_MS = 8;
   localparam int IW_TIMEOUT_MS = 400;
   localparam logic [9:0] CRC_ERR_LIMIT = 10'h392;
   // receive events from the line side framer core
   typedef struct packed {
      logic bit_valid;
      logic bit_val;
      logic fas_found;
      logic fas_lost;
      logic mf_found;
      logic crc_err;
      logic [1:0] submf_err;
      logic tx_mf_start;
   } e1f_rx_t;
   // controls toward the transmit and search logic
   typedef struct packed {
      logic t1_mode;
      logic digital_if;
      logic [2:0] line_code;
      logic rai;
      logic [1:0] ebit;
      logic search_restart;
      logic mf_search;
      logic los;
   } e1f_tx_t;
endpackage

// *** design/e1f_sync_top.sv ***
// e1f_sync_top: control registers, los detection, sync strategy and alarm insertion
// assumes line events synchronous to clk_sys and a host on the plain register port
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
// Overview of operation
// - line standard bit low keeps E1 mode; high selects T1/J1 mode.
// - analog side codes AMI/HDB3; digital side adds NRZ, CMI, CMI with HDB3.
// - detect count 0x0a declares loss of signal after 176 zeros.
// - recover count 0x15 clears loss after 22 ones inside the interval.
// - auto status inserts received submultiframe CRC errors as next E-bits.
// - asynchronous state sends E-bits equal to the polarity control.
// - auto remote alarm follows loss of frame alignment, removed on regain.
// - CRC4 framing with auto resync restarts search after 8 ms without multiframe.
// - auto multiframe resync restarts search above 914 CRC errors per second.
// - interworking holds doubleframe after 400 ms and raises an event.
// - extended interworking raises remote alarm at 400 ms and keeps searching.
// - control registers read back; command register is write only.
// - reset leaves doubleframe E1 with framing registers zero.
// - reset sets every interrupt mask bit to one.
module e1f_sync_top
   import e1f_pkg::*;
#(
   parameter int MS_CYC = e1f_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rst,
   // register port
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [7:0]      reg_rdata,
   // line side
   input  e1f_pkg::e1f_rx_t     rx_ev,
   output e1f_pkg::e1f_tx_t     tx_ctl,
   // interrupt
   output logic                 irq
);
   import e1f_pkg::*;

   typedef enum logic [1:0] {ST_SEARCH, ST_BASIC, ST_MULTI, ST_DF_HOLD} e1f_state_t;

   logic [7:0]  fm_one, fm_two, fm_three, line_cfg, los_det, los_rec, spare_ctl;
   logic [7:0]  int_stat, int_mask, next_int_stat, status;
   logic        los, rx_reset, restart, iw_rai, tx_rai;
   logic [12:0] zero_cnt, win_cnt, det_lim;
   logic [8:0]  ones_cnt, rec_lim;
   logic [15:0] cyc_cnt;
   logic        ms_tick, sec_tick;
   logic [9:0]  sec_ms, st_ms, crc_cnt;
   logic        crc_over;
   logic [1:0]  submf_hold, ebit;
   logic [2:0]  code_eff;
   logic [7:0]  ev;
   logic        los_set_ev, los_clr_ev, mf_ev, iw_ev;
   e1f_state_t  state;

   wire logic [1:0] rfs = fm_two[B_RFS_HI:B_RFS_LO];
   wire logic       wr_hit_cmd = reg_wr && reg_addr == OFS_COMMAND;

   // control registers, all read/write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fm_one    <= RST_ZERO;
         fm_two    <= RST_ZERO;
         fm_three  <= RST_ZERO;
         line_cfg  <= RST_ZERO;
         los_det   <= RST_ZERO;
         los_rec   <= RST_ZERO;
         spare_ctl <= RST_ZERO;
         int_mask  <= RST_MASK;
      end else if (reg_wr) begin
         case (reg_addr)
            OFS_FM_ONE:      fm_one    <= reg_wdata;
            OFS_FM_TWO:      fm_two    <= reg_wdata;
            OFS_FM_THREE:    fm_three  <= reg_wdata;
            OFS_LINE_CFG:    line_cfg  <= reg_wdata;
            OFS_LOS_DETECT:  los_det   <= reg_wdata;
            OFS_LOS_RECOVER: los_rec   <= reg_wdata;
            OFS_SPARE_CTL:   spare_ctl <= reg_wdata;
            OFS_INT_MASK:    int_mask  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // command register: write only pulse
   always_ff @(posedge clk_sys) begin
      if (rst)
         rx_reset <= 1'b0;
      else
         rx_reset <= wr_hit_cmd && reg_wdata[B_RX_RESET];
   end

   // read data, one cycle after the strobe
   assign status = {3'h0, iw_rai, tx_rai, state == ST_MULTI, state == ST_SEARCH, los};
   always_ff @(posedge clk_sys) begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         case (reg_addr)
            OFS_FM_ONE:      reg_rdata <= fm_one;
            OFS_FM_TWO:      reg_rdata <= fm_two;
            OFS_FM_THREE:    reg_rdata <= fm_three;
            OFS_LINE_CFG:    reg_rdata <= line_cfg;
            OFS_LOS_DETECT:  reg_rdata <= los_det;
            OFS_LOS_RECOVER: reg_rdata <= los_rec;
            OFS_SPARE_CTL:   reg_rdata <= spare_ctl;
            OFS_STATUS:      reg_rdata <= status;
            OFS_INT_STAT:    reg_rdata <= int_stat;
            OFS_INT_MASK:    reg_rdata <= int_mask;
            default:         reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

   // millisecond and second timers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cyc_cnt  <= 16'h0000;
         ms_tick  <= 1'b0;
         sec_ms   <= 10'h000;
         sec_tick <= 1'b0;
      end else begin
         ms_tick  <= cyc_cnt == 16'(MS_CYC - 1);
         cyc_cnt  <= (cyc_cnt == 16'(MS_CYC - 1)) ? 16'h0000 : cyc_cnt + 16'h0001;
         sec_tick <= ms_tick && sec_ms == 10'(SEC_MS - 1);
         if (ms_tick)
            sec_ms <= (sec_ms == 10'(SEC_MS - 1)) ? 10'h000 : sec_ms + 10'h001;
      end
   end

   // loss of signal: zero run and recovery window
   assign det_lim = {los_det + 9'h001, 4'h0};
   assign rec_lim = {1'b0, los_rec} + 9'h001;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         los      <= 1'b0;
         zero_cnt <= 13'h0000;
         win_cnt  <= 13'h0000;
         ones_cnt <= 9'h000;
      end else if (rx_ev.bit_valid) begin
         if (!los) begin
            win_cnt  <= 13'h0000;
            ones_cnt <= 9'h000;
            if (rx_ev.bit_val)
               zero_cnt <= 13'h0000;
            else if (zero_cnt + 13'h0001 >= det_lim) begin
               los      <= 1'b1;
               zero_cnt <= 13'h0000;
            end else
               zero_cnt <= zero_cnt + 13'h0001;
         end else begin
            if (rx_ev.bit_val && ones_cnt + 9'h001 >= rec_lim) begin
               los      <= 1'b0;
               win_cnt  <= 13'h0000;
               ones_cnt <= 9'h000;
            end else if (win_cnt + 13'h0001 >= det_lim) begin
               win_cnt  <= 13'h0000;
               ones_cnt <= 9'h000;
            end else begin
               win_cnt  <= win_cnt + 13'h0001;
               ones_cnt <= ones_cnt + {8'h00, rx_ev.bit_val};
            end
         end
      end
   end

   // crc error count per second window
   always_ff @(posedge clk_sys) begin
      if (rst || sec_tick || restart) begin
         crc_cnt  <= 10'h000;
      end else if (rx_ev.crc_err && crc_cnt <= CRC_ERR_LIMIT) begin
         crc_cnt <= crc_cnt + 10'h001;
      end
   end
   assign crc_over = fm_two[B_MF_RESYNC] && rx_ev.crc_err && crc_cnt == CRC_ERR_LIMIT
                     && (state == ST_BASIC || state == ST_MULTI);

   // framing search strategy
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state   <= ST_SEARCH;
         st_ms   <= 10'h000;
         restart <= 1'b0;
         iw_rai  <= 1'b0;
      end else begin
         restart <= 1'b0;
         if (ms_tick && st_ms != 10'h3ff)
            st_ms <= st_ms + 10'h001;
         if (rx_reset || crc_over) begin
            state   <= ST_SEARCH;
            restart <= 1'b1;
            iw_rai  <= 1'b0;
         end else if (rx_ev.fas_lost) begin
            state  <= ST_SEARCH;
            iw_rai <= 1'b0;
         end else begin
            case (state)
               ST_SEARCH: if (rx_ev.fas_found) begin
                  state <= ST_BASIC;
                  st_ms <= 10'h000;
               end
               ST_BASIC: if (rx_ev.mf_found && rfs[1]) begin
                  state  <= ST_MULTI;
                  iw_rai <= 1'b0;
               end else if (rfs == RFS_CRC4 && fm_one[B_RESYNC]
                            && st_ms >= 10'(MF_TIMEOUT_MS)) begin
                  state   <= ST_SEARCH;
                  restart <= 1'b1;
               end else if (rfs == RFS_INTERWK && ms_tick
                            && st_ms == 10'(IW_TIMEOUT_MS - 1)) begin
                  if (fm_three[B_EXT_IW])
                     iw_rai <= 1'b1;
                  else
                     state <= ST_DF_HOLD;
               end
               ST_MULTI:   if (!rfs[1]) state <= ST_BASIC;
               ST_DF_HOLD: if (rfs != RFS_INTERWK) state <= ST_BASIC;
               default:    state <= ST_SEARCH;
            endcase
         end
      end
   end

   // remote alarm
   assign tx_rai = (fm_two[B_AUTO_RAI] && state == ST_SEARCH) || iw_rai;

   // e-bit insertion per outgoing multiframe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         submf_hold <= 2'h0;
         ebit       <= 2'h3;
      end else if (rx_ev.tx_mf_start) begin
         submf_hold <= 2'h0;
         if (state == ST_SEARCH)
            ebit <= {2{spare_ctl[B_EBIT_POL]}};
         else if (spare_ctl[B_AUTO_EBIT])
            ebit <= ~(submf_hold | rx_ev.submf_err);
         else
            ebit <= 2'h3;
      end else
         submf_hold <= submf_hold | rx_ev.submf_err;
   end

   // line code: analog side limited to ami or hdb3
   always_comb begin
      code_eff = line_cfg[2:0];
      if (code_eff > LC_CMI_HDB3)
         code_eff = LC_HDB3;
      if (!line_cfg[B_DIGITAL] && code_eff != LC_AMI)
         code_eff = LC_HDB3;
   end

   // line side outputs
   always_ff @(posedge clk_sys) begin
      if (rst)
         tx_ctl <= '0;
      else begin
         tx_ctl.t1_mode        <= fm_one[B_LINE_STD];
         tx_ctl.digital_if     <= line_cfg[B_DIGITAL];
         tx_ctl.line_code      <= code_eff;
         tx_ctl.rai            <= tx_rai;
         tx_ctl.ebit           <= ebit;
         tx_ctl.search_restart <= restart;
         tx_ctl.mf_search      <= state == ST_BASIC && rfs[1];
         tx_ctl.los            <= los;
      end
   end

   // interrupt status, set wins over write one to clear
   always_comb begin
      los_set_ev = !los && rx_ev.bit_valid && !rx_ev.bit_val && zero_cnt + 13'h0001 >= det_lim;
      los_clr_ev = rx_ev.bit_valid && rx_ev.bit_val && ones_cnt + 9'h001 >= rec_lim;
      mf_ev      = state == ST_BASIC && rx_ev.mf_found && rfs[1] && !rx_ev.fas_lost;
      iw_ev      = state == ST_BASIC && rfs == RFS_INTERWK && ms_tick
                   && st_ms == 10'(IW_TIMEOUT_MS - 1) && !rx_ev.mf_found;
      ev         = {2'h0, restart, iw_ev, state != ST_MULTI && mf_ev,
                    state != ST_SEARCH && rx_ev.fas_lost, los && los_clr_ev, los_set_ev};
   end
   always_comb begin
      next_int_stat = int_stat;
      if (reg_wr && reg_addr == OFS_INT_STAT)
         next_int_stat = int_stat & ~reg_wdata;
      next_int_stat = next_int_stat | ev;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_stat <= 8'h00;
         irq      <= 1'b0;
      end else begin
         int_stat <= next_int_stat;
         irq      <= |(next_int_stat & ~int_mask);
      end
   end

   // checks
   los_detect_a: assert property (@(posedge clk_sys) disable iff (rst)
      los_set_ev |=> los)
      else $error("loss of signal not declared at zero limit");
   los_recover_a: assert property (@(posedge clk_sys) disable iff (rst)
      (los && los_clr_ev) |=> !los)
      else $error("loss of signal not cleared at ones limit");
   remote_alarm_a: assert property (@(posedge clk_sys) disable iff (rst)
      (fm_two[B_AUTO_RAI] && state == ST_SEARCH) |-> ##1 tx_ctl.rai)
      else $error("remote alarm missing while alignment lost");
   ebit_async_a: assert property (@(posedge clk_sys) disable iff (rst)
      (rx_ev.tx_mf_start && state == ST_SEARCH) |=> ebit == {2{$past(spare_ctl[B_EBIT_POL])}})
      else $error("asynchronous e-bit does not follow polarity");
   ebit_auto_a: assert property (@(posedge clk_sys) disable iff (rst)
      (rx_ev.tx_mf_start && state != ST_SEARCH && spare_ctl[B_AUTO_EBIT])
      |=> ebit == ~($past(submf_hold) | $past(rx_ev.submf_err)))
      else $error("automatic e-bits do not follow submultiframe errors");
   align_lost_a: assert property (@(posedge clk_sys) disable iff (rst)
      rx_ev.fas_lost |=> state == ST_SEARCH)
      else $error("alignment lost flag not set on loss");
   mf_timeout_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state == ST_BASIC && rfs == RFS_CRC4 && fm_one[B_RESYNC] && st_ms >= 10'(MF_TIMEOUT_MS)
       && !rx_ev.mf_found && !rx_ev.fas_lost) |=> restart && state == ST_SEARCH)
      else $error("multiframe timeout did not restart search");
   crc_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
      crc_over |=> state == ST_SEARCH ##1 tx_ctl.search_restart)
      else $error("crc error limit did not restart search");
   iw_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (iw_ev && !fm_three[B_EXT_IW] && !rx_reset && !crc_over && !rx_ev.fas_lost)
      |=> state == ST_DF_HOLD && int_stat[I_IW400])
      else $error("interworking hold or event missing");
   iw_ext_a: assert property (@(posedge clk_sys) disable iff (rst)
      (iw_ev && fm_three[B_EXT_IW] && !rx_reset && !crc_over && !rx_ev.fas_lost)
      |=> iw_rai && state == ST_BASIC ##1 tx_ctl.rai)
      else $error("extended interworking alarm missing");
   std_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      ##1 tx_ctl.t1_mode == $past(fm_one[B_LINE_STD]))
      else $error("line standard output wrong");
   mask_reset_a: assert property (@(posedge clk_sys)
      rst |=> int_mask == RST_MASK && fm_two == RST_ZERO)
      else $error("mask or framing reset value wrong");
endmodule

// *** dv/e1f_line_model.sv ***
// e1f_line_model: remote line equipment, sends line bits and framing events
// assumes one caller at a time, all events synchronous to clk_sys
`timescale 1ns/1ns
module e1f_line_model
   import e1f_pkg::*;
(
   // clock
   input  wire logic        clk_sys,
   // received line events
   output e1f_pkg::e1f_rx_t rx_ev
);
   import e1f_pkg::*;
   logic last = 1'b0;
   initial rx_ev = '0;
   // each unit is one cycle wide, then one idle cycle
   // between bits the data line shows the inverse of the last bit
   task automatic put(input e1f_rx_t v, input int n);
      e1f_rx_t idle;
      repeat (n) begin
         @(posedge clk_sys);
         if (v.bit_valid)
            last = v.bit_val;
         else
            v.bit_val = ~last;
         rx_ev <= v;
         @(posedge clk_sys);
         idle = '0;
         idle.bit_val = ~last;
         rx_ev <= idle;
      end
   endtask
endmodule

// *** dv/e1f_sync_top_test.sv ***
// e1f_sync_top_test: self-checking bench for the e1 sync and alarm block
// assumes the line model in place of the remote equipment, 4 cycle ms tick
`timescale 1ns/1ns
module e1f_sync_top_test;
   import e1f_pkg::*;
   localparam int      MSC    = 4;
   localparam e1f_rx_t ZERO   = '{bit_valid: 1'b1, default: 1'b0};
   localparam e1f_rx_t ONE    = '{bit_valid: 1'b1, bit_val: 1'b1, default: 1'b0};
   localparam e1f_rx_t FAS_UP = '{fas_found: 1'b1, default: 1'b0};
   localparam e1f_rx_t FAS_DN = '{fas_lost: 1'b1, default: 1'b0};
   localparam e1f_rx_t MF_UP  = '{mf_found: 1'b1, default: 1'b0};
   localparam e1f_rx_t CRC    = '{crc_err: 1'b1, default: 1'b0};
   logic       clk_sys   = 1'b0;
   logic       rst       = 1'b1;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [7:0] reg_rdata;
   e1f_rx_t    rx_ev;
   e1f_tx_t    tx_ctl;
   logic       irq;
   logic [7:0] seed      = 8'h48;
   int         fail_count = 0;
   int         compares   = 0;
   int         restarts   = 0;
   int         base       = 0;
   int         cyc        = 0;
   always #50 clk_sys = ~clk_sys;
   e1f_sync_top #(.MS_CYC(MSC)) dut (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .rx_ev     (rx_ev),
      .tx_ctl    (tx_ctl),
      .irq       (irq)
   );
   e1f_line_model line (.clk_sys(clk_sys), .rx_ev(rx_ev));
   always @(posedge clk_sys) begin
      cyc <= rst ? 0 : cyc + 1;
      if (tx_ctl.search_restart === 1'b1)
         restarts <= restarts + 1;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // analog side only knows AMI and HDB3
   function automatic logic [2:0] exp_code(input logic [2:0] c, input logic dig);
      if (c > LC_CMI_HDB3 || (!dig && c != LC_AMI))
         return LC_HDB3;
      return c;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                     input string msg);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, e, msg);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic nres(input int e, input string msg);
      chk(8'(restarts - base), 8'(e), msg);
   endtask
   task automatic finish_test();
      $display("compares %0d, fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #3000000;
      fail_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      waitc(1);
      rd(OFS_INT_MASK, RST_MASK, 8'hff, "mask reset");
      rd(OFS_FM_ONE, RST_ZERO, 8'hff, "fm one reset");
      rd(OFS_FM_TWO, RST_ZERO, 8'hff, "fm two reset");
      chk(8'(tx_ctl.t1_mode), 8'h00, "e1 at reset");
      for (int a = 0; a < 7; a++) begin
         seed = lfsr(seed);
         wr(8'(a), seed);
         rd(8'(a), seed, 8'hff, "read back");
         wr(8'(a), 8'h00);
      end
      wr(OFS_FM_ONE, 8'h08);
      waitc(2);
      chk(8'(tx_ctl.t1_mode), 8'h01, "t1 select");
      wr(OFS_FM_ONE, 8'h00);
      wr(OFS_COMMAND, 8'h00);
      rd(OFS_COMMAND, 8'h00, 8'hff, "command read");
      wr(8'h3c, 8'h00);
      rd(8'h3c, 8'h00, 8'hff, "unused read");
      for (int k = 0; k < 16; k++) begin
         wr(OFS_LINE_CFG, 8'(k));
         waitc(2);
         chk(8'(tx_ctl.line_code), 8'(exp_code(3'(k), k[3])), "line code");
         chk(8'(tx_ctl.digital_if), 8'(k[3]), "digital");
      end
      // loss of signal with its interrupt unmasked
      wr(OFS_LOS_DETECT, 8'h0a);
      wr(OFS_LOS_RECOVER, 8'h15);
      wr(OFS_INT_STAT, 8'hff);
      wr(OFS_INT_MASK, 8'hfe);
      line.put(ZERO, 175);
      waitc(3);
      chk(8'(tx_ctl.los), 8'h00, "175 zeros");
      line.put(ZERO, 1);
      waitc(3);
      chk(8'(tx_ctl.los), 8'h01, "176 zeros");
      chk(8'(irq), 8'h01, "los irq");
      line.put(ONE, 21);
      waitc(3);
      chk(8'(tx_ctl.los), 8'h01, "21 ones");
      line.put(ONE, 1);
      waitc(3);
      chk(8'(tx_ctl.los), 8'h00, "22 ones");
      wr(OFS_INT_STAT, 8'h01);
      waitc(2);
      chk(8'(irq), 8'h00, "irq clear, rest masked");
      wr(OFS_INT_MASK, 8'hff);
      // remote alarm and E-bits around alignment
      wr(OFS_FM_TWO, 8'h10);
      line.put(FAS_DN, 1);
      waitc(3);
      chk(8'(tx_ctl.rai), 8'h01, "rai unaligned");
      rd(OFS_STATUS, 8'h02, 8'h02, "lost flag");
      for (int p = 0; p < 2; p++) begin
         wr(OFS_SPARE_CTL, 8'(p << B_EBIT_POL));
         line.put('{tx_mf_start: 1'b1, default: 1'b0}, 1);
         waitc(2);
         chk(8'(tx_ctl.ebit), 8'(p * 3), "async ebit");
      end
      line.put(FAS_UP, 1);
      waitc(3);
      chk(8'(tx_ctl.rai), 8'h00, "rai removed");
      rd(OFS_STATUS, 8'h00, 8'h02, "lost cleared");
      wr(OFS_SPARE_CTL, 8'h08);
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         line.put('{tx_mf_start: 1'b1, submf_err: seed[1:0], default: 1'b0}, 1);
         waitc(2);
         chk(8'(tx_ctl.ebit), {6'h00, ~seed[1:0]}, "submf ebit");
      end
      // crc4 multiframe search timeout
      wr(OFS_FM_TWO, 8'h80);
      wr(OFS_FM_ONE, 8'h02);
      line.put(FAS_DN, 1);
      line.put(FAS_UP, 1);
      base = restarts;
      waitc(25);
      nres(0, "early restart");
      waitc(15);
      nres(1, "8 ms restart");
      line.put(FAS_UP, 1);
      line.put(MF_UP, 1);
      base = restarts;
      waitc(50);
      nres(0, "mf aligned");
      // crc error threshold per second, start clear of a second boundary
      wr(OFS_FM_ONE, 8'h00);
      wr(OFS_FM_TWO, 8'h01);
      while (cyc % (MSC * SEC_MS) != 100)
         @(posedge clk_sys);
      wr(OFS_COMMAND, 8'h01);
      waitc(4);
      line.put(FAS_UP, 1);
      base = restarts;
      line.put(CRC, 914);
      waitc(3);
      nres(0, "914 errors");
      line.put(CRC, 1);
      waitc(3);
      nres(1, "915 errors");
      line.put(FAS_UP, 1);
      base = restarts;
      line.put(CRC, 900);
      waitc(4100);
      line.put(CRC, 100);
      waitc(3);
      nres(0, "window restart");
      // interworking, plain then extended
      wr(OFS_FM_ONE, 8'h02);
      wr(OFS_FM_TWO, 8'hc0);
      for (int x = 0; x < 2; x++) begin
         wr(OFS_FM_THREE, 8'(x));
         wr(OFS_COMMAND, 8'h01);
         waitc(4);
         wr(OFS_INT_STAT, 8'hff);
         line.put(FAS_UP, 1);
         base = restarts;
         waitc(1580);
         rd(OFS_INT_STAT, 8'h00, 8'h10, "early 400 ms");
         chk(8'(tx_ctl.rai), 8'h00, "early alarm");
         waitc(40);
         rd(OFS_INT_STAT, 8'h10, 8'h10, "400 ms event");
         chk(8'(tx_ctl.rai), 8'(x), "iw alarm");
         chk(8'(tx_ctl.mf_search), 8'(x), "mf search");
         nres(0, "iw resync");
      end
      finish_test();
   end
endmodule
